// File: wdrs_top.v
// watchdog counter, reset-cause flags, stop-mode halt select and
// pin-change wake sources behind an AXI4-Lite slave.
// assumes all inputs synchronous to i_clk_sys; i_nrst is the power-on reset;
// the rc oscillator tick arrives as a one-cycle pulse on i_rc_tick.
`timescale 1ns/100ps
`include "wdrs_defs.vh"

module wdrs_top #(
  parameter CNT_W = 24,
  parameter PIN_W = 8
) (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // system events
  input wire i_stop_mode,
  input wire i_pin_reset,
  input wire i_wdt_refresh,
  input wire i_rc_tick,
  input wire [PIN_W-1:0] i_port_pins,
  // system outputs
  output reg o_wdt_reset,
  output reg o_stop_recover,
  output reg o_rc_run,
  output reg o_irq,
  // axi4-lite write address
  input wire [31:0] i_s_awaddr,
  input wire i_s_awvalid,
  output reg o_s_awready,
  // axi4-lite write data
  input wire [31:0] i_s_wdata,
  input wire [3:0] i_s_wstrb,
  input wire i_s_wvalid,
  output reg o_s_wready,
  // axi4-lite write response
  output reg [1:0] o_s_bresp,
  output reg o_s_bvalid,
  input wire i_s_bready,
  // axi4-lite read address
  input wire [31:0] i_s_araddr,
  input wire i_s_arvalid,
  output reg o_s_arready,
  // axi4-lite read data
  output reg [31:0] o_s_rdata,
  output reg [1:0] o_s_rresp,
  output reg o_s_rvalid,
  input wire i_s_rready
);

  // ========================================================================
  // reset release
  reg rst_meta_q;
  reg rst_n_q;

  always @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ========================================================================
  // address decode: 4-bit index from an aligned byte address, 4'hf unmapped
  function [3:0] reg_index;
    input [31:0] addr;
    begin
      if (addr[1:0] != 2'b00 || addr[31:5] != 27'h000_0000) begin
        reg_index = 4'hf;
      end else begin
        case (addr[4:2])
          3'd0: reg_index = `WDRS_IDX_STATUS;
          3'd1: reg_index = `WDRS_IDX_RLD_UPPER;
          3'd2: reg_index = `WDRS_IDX_RLD_HIGH;
          3'd3: reg_index = `WDRS_IDX_RLD_LOW;
          3'd5: reg_index = `WDRS_IDX_WAKE_EN;
          3'd6: reg_index = `WDRS_IDX_IRQ_STATUS;
          3'd7: reg_index = `WDRS_IDX_IRQ_MASK;
          default: reg_index = 4'hf;
        endcase
      end
    end
  endfunction

  // one byte lane of a register word
  function [7:0] byte_of;
    input [31:0] word;
    input [1:0] lane;
    begin
      byte_of = word[lane*8 +: 8];
    end
  endfunction

  // ========================================================================
  // state
  reg por_q;
  reg stop_q;
  reg wdt_q;
  reg ext_q;
  reg halt_sel_q;
  reg [CNT_W-1:0] reload_q;
  reg [CNT_W-1:0] count_q;
  reg [PIN_W-1:0] wake_en_q;
  reg [PIN_W-1:0] pins_prev_q;
  reg [`WDRS_IRQ_W-1:0] irq_st_q;
  reg [`WDRS_IRQ_W-1:0] irq_mask_q;
  reg [31:0] awaddr_q;
  reg aw_have_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_have_q;

  // ========================================================================
  // watchdog events
  wire halted = i_stop_mode & halt_sel_q;
  wire tick = i_rc_tick & ~halted;
  wire timeout = tick & ~i_wdt_refresh & (count_q == {CNT_W{1'b0}});
  wire to_stop = timeout & i_stop_mode;
  wire to_run = timeout & ~i_stop_mode;
  wire pin_wake = i_stop_mode & (|((i_port_pins ^ pins_prev_q) & wake_en_q));
  wire recover = to_stop | pin_wake;

  // ========================================================================
  // bus decode
  wire wr_go = aw_have_q & w_have_q & ~o_s_bvalid;
  wire [3:0] wr_idx = reg_index(awaddr_q);
  wire wr_lane0 = wr_go & wstrb_q[0];
  wire rd_go = i_s_arvalid & o_s_arready;
  wire [3:0] rd_idx = reg_index(i_s_araddr);
  wire rd_clear = rd_go & (rd_idx == `WDRS_IDX_STATUS);
  wire [31:0] count_word = {{(32-CNT_W){1'b0}}, count_q};

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (rd_idx)
      `WDRS_IDX_STATUS: begin
        rd_mux[`WDRS_ST_POR] = por_q;
        rd_mux[`WDRS_ST_STOP] = stop_q;
        rd_mux[`WDRS_ST_WDT] = wdt_q;
        rd_mux[`WDRS_ST_EXT] = ext_q;
        rd_mux[`WDRS_ST_SM] = halt_sel_q;
      end
      `WDRS_IDX_RLD_UPPER: rd_mux[7:0] = byte_of(count_word, 2'd2);
      `WDRS_IDX_RLD_HIGH: rd_mux[7:0] = byte_of(count_word, 2'd1);
      `WDRS_IDX_RLD_LOW: rd_mux[7:0] = byte_of(count_word, 2'd0);
      `WDRS_IDX_WAKE_EN: rd_mux[PIN_W-1:0] = wake_en_q;
      `WDRS_IDX_IRQ_STATUS: rd_mux[`WDRS_IRQ_W-1:0] = irq_st_q;
      `WDRS_IDX_IRQ_MASK: rd_mux[`WDRS_IRQ_W-1:0] = irq_mask_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ========================================================================
  // reset-cause flags: events win over the read clear
  reg por_d;
  reg stop_d;
  reg wdt_d;
  reg ext_d;

  always @* begin
    por_d = por_q;
    stop_d = stop_q;
    wdt_d = wdt_q;
    ext_d = ext_q;
    if (timeout | recover) begin
      por_d = 1'b0;
    end else if (rd_clear) begin
      por_d = 1'b0;
    end
    if (recover) begin
      stop_d = 1'b1;
    end else if (to_run | rd_clear) begin
      stop_d = 1'b0;
    end
    if (timeout) begin
      wdt_d = 1'b1;
    end else if (pin_wake | rd_clear) begin
      wdt_d = 1'b0;
    end
    if (i_pin_reset) begin
      ext_d = 1'b1;
    end else if (pin_wake | rd_clear) begin
      ext_d = 1'b0;
    end
  end

  always @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      por_q <= 1'b1;
      stop_q <= 1'b0;
      wdt_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      por_q <= por_d;
      stop_q <= stop_d;
      wdt_q <= wdt_d;
      ext_q <= ext_d;
    end
  end

  // ========================================================================
  // watchdog count: refresh or time-out reloads, a live tick steps down
  reg [CNT_W-1:0] count_d;

  always @* begin
    if (i_wdt_refresh | timeout) begin
      count_d = reload_q;
    end else if (tick) begin
      count_d = count_q - 1'b1;
    end else begin
      count_d = count_q;
    end
  end

  // ========================================================================
  // watchdog counter and control registers
  always @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reload_q <= `WDRS_RST_RELOAD;
      count_q <= `WDRS_RST_RELOAD;
      halt_sel_q <= 1'b0;
      wake_en_q <= `WDRS_RST_WAKE_EN;
      irq_mask_q <= `WDRS_RST_IRQ_MASK;
      pins_prev_q <= {PIN_W{1'b0}};
      o_rc_run <= 1'b1;
      o_wdt_reset <= 1'b0;
      o_stop_recover <= 1'b0;
    end else begin
      pins_prev_q <= i_port_pins;
      o_rc_run <= ~halted;
      o_wdt_reset <= to_run;
      o_stop_recover <= recover;
      count_q <= count_d;
      if (wr_lane0) begin
        case (wr_idx)
          // reserved bits are ignored on write
          `WDRS_IDX_STATUS: halt_sel_q <= wdata_q[`WDRS_ST_SM];
          `WDRS_IDX_RLD_UPPER: reload_q[23:16] <= wdata_q[7:0];
          `WDRS_IDX_RLD_HIGH: reload_q[15:8] <= wdata_q[7:0];
          `WDRS_IDX_RLD_LOW: reload_q[7:0] <= wdata_q[7:0];
          `WDRS_IDX_WAKE_EN: wake_en_q <= wdata_q[PIN_W-1:0];
          `WDRS_IDX_IRQ_MASK: irq_mask_q <= wdata_q[`WDRS_IRQ_W-1:0];
          default: halt_sel_q <= halt_sel_q;
        endcase
      end
    end
  end

  // ========================================================================
  // interrupt status, write one to clear, set wins
  wire [`WDRS_IRQ_W-1:0] irq_set = {i_pin_reset, recover, timeout};
  wire [`WDRS_IRQ_W-1:0] irq_clr =
    (wr_lane0 && wr_idx == `WDRS_IDX_IRQ_STATUS) ? wdata_q[`WDRS_IRQ_W-1:0]
                                                 : {`WDRS_IRQ_W{1'b0}};
  wire [`WDRS_IRQ_W-1:0] irq_st_d = (irq_st_q & ~irq_clr) | irq_set;

  always @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_st_q <= {`WDRS_IRQ_W{1'b0}};
      o_irq <= 1'b0;
    end else begin
      irq_st_q <= irq_st_d;
      o_irq <= |(irq_st_d & irq_mask_q);
    end
  end

  // ========================================================================
  // axi4-lite write channel
  always @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_s_awready <= 1'b1;
      o_s_wready <= 1'b1;
      o_s_bvalid <= 1'b0;
      o_s_bresp <= `WDRS_RESP_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (i_s_awvalid & o_s_awready) begin
        awaddr_q <= i_s_awaddr;
        aw_have_q <= 1'b1;
        o_s_awready <= 1'b0;
      end
      if (i_s_wvalid & o_s_wready) begin
        wdata_q <= i_s_wdata;
        wstrb_q <= i_s_wstrb;
        w_have_q <= 1'b1;
        o_s_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        o_s_bvalid <= 1'b1;
        o_s_bresp <= (wr_idx == 4'hf) ? `WDRS_RESP_SLVERR : `WDRS_RESP_OKAY;
      end
      if (o_s_bvalid & i_s_bready) begin
        o_s_bvalid <= 1'b0;
        o_s_awready <= 1'b1;
        o_s_wready <= 1'b1;
      end
    end
  end

  // ========================================================================
  // axi4-lite read channel
  always @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      o_s_arready <= 1'b1;
      o_s_rvalid <= 1'b0;
      o_s_rdata <= 32'h0000_0000;
      o_s_rresp <= `WDRS_RESP_OKAY;
    end else begin
      if (rd_go) begin
        o_s_arready <= 1'b0;
        o_s_rvalid <= 1'b1;
        o_s_rdata <= rd_mux;
        o_s_rresp <= (rd_idx == 4'hf) ? `WDRS_RESP_SLVERR : `WDRS_RESP_OKAY;
      end
      if (o_s_rvalid & i_s_rready) begin
        o_s_rvalid <= 1'b0;
        o_s_arready <= 1'b1;
      end
    end
  end

endmodule

// File: wdrs_defs.vh
// constants for the watchdog, reset-cause and wake-source block
// assumes a 32-bit AXI4-Lite register bus, one register per aligned word
`ifndef WDRS_DEFS_VH
`define WDRS_DEFS_VH

// ==========================================================================
// register indices, byte address is four times the index
`define WDRS_IDX_STATUS 4'h0
`define WDRS_IDX_RLD_UPPER 4'h1
`define WDRS_IDX_RLD_HIGH 4'h2
`define WDRS_IDX_RLD_LOW 4'h3
`define WDRS_IDX_WAKE_EN 4'h5
`define WDRS_IDX_IRQ_STATUS 4'h6
`define WDRS_IDX_IRQ_MASK 4'h7

// ==========================================================================
// reset-cause status fields
`define WDRS_ST_POR 7
`define WDRS_ST_STOP 6
`define WDRS_ST_WDT 5
`define WDRS_ST_EXT 4
`define WDRS_ST_SM 0

// ==========================================================================
// interrupt status and mask fields
`define WDRS_IRQ_TIMEOUT 0
`define WDRS_IRQ_RECOVER 1
`define WDRS_IRQ_PINRST 2
`define WDRS_IRQ_W 3

// ==========================================================================
// reset values
`define WDRS_RST_RELOAD 24'hff_ffff
`define WDRS_RST_WAKE_EN 8'h00
`define WDRS_RST_IRQ_MASK 3'h0

// ==========================================================================
// bus answers
`define WDRS_RESP_OKAY 2'b00
`define WDRS_RESP_SLVERR 2'b10

`endif

// File: wdrs_props.sv
// port checker for the watchdog, reset-cause and wake block
// assumes it is bound onto wdrs_top
`timescale 1ns/100ps
module wdrs_props (
  // clock and reset
  input wire i_clk_sys,
  input wire i_nrst,
  // system side
  input wire i_stop_mode,
  input wire o_wdt_reset,
  input wire o_stop_recover,
  input wire o_rc_run,
  // register bus
  input wire i_s_awvalid,
  input wire o_s_awready,
  input wire i_s_wvalid,
  input wire o_s_wready,
  input wire o_s_bvalid,
  input wire i_s_bready,
  input wire i_s_arvalid,
  input wire o_s_arready,
  input wire o_s_rvalid,
  input wire [31:0] o_s_rdata
);
  default clocking @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_nrst);
  // ==========================================================
  // watchdog and wake events
  wdt_pulse_a: assert property (o_wdt_reset |=> !o_wdt_reset)
    else $error("reset request longer than one cycle");
  run_timeout_a: assert property (o_wdt_reset |-> !$past(i_stop_mode))
    else $error("reset request raised in stop");
  stop_wake_a: assert property (o_stop_recover |-> $past(i_stop_mode))
    else $error("recovery raised outside stop");
  rc_running_a: assert property (!i_stop_mode |=> o_rc_run)
    else $error("oscillator halted outside stop");
  // ==========================================================
  // register bus
  wr_answer_a: assert property (i_s_awvalid && o_s_awready && i_s_wvalid && o_s_wready
    |=> ##1 o_s_bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (i_s_arvalid && o_s_arready |=> o_s_rvalid)
    else $error("read answer late");
  b_release_a: assert property (o_s_bvalid && i_s_bready |=> !o_s_bvalid)
    else $error("write answer not released");
  rd_upper_a: assert property (o_s_rvalid |-> o_s_rdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
endmodule

bind wdrs_top wdrs_props u_props (.i_clk_sys, .i_nrst, .i_stop_mode, .o_wdt_reset,
  .o_stop_recover, .o_rc_run, .i_s_awvalid, .o_s_awready, .i_s_wvalid, .o_s_wready,
  .o_s_bvalid, .i_s_bready, .i_s_arvalid, .o_s_arready, .o_s_rvalid, .o_s_rdata);

// File: watchdog_reset_status_wake_tb.sv
// self-checking bench for the watchdog, reset-cause and wake block
// assumes wdrs_top and its constants header in the same folder
`timescale 1ns/100ps
`include "wdrs_defs.vh"
module watchdog_reset_status_wake_tb;
  logic i_clk_sys, i_nrst, i_stop_mode, i_pin_reset, i_wdt_refresh, i_rc_tick;
  logic [7:0] i_port_pins, en;
  logic o_wdt_reset, o_stop_recover, o_rc_run, o_irq;
  logic [31:0] i_s_awaddr, i_s_wdata, i_s_araddr, o_s_rdata, d;
  logic [3:0] i_s_wstrb;
  logic i_s_awvalid, o_s_awready, i_s_wvalid, o_s_wready, o_s_bvalid, i_s_bready;
  logic i_s_arvalid, o_s_arready, o_s_rvalid, i_s_rready;
  logic [1:0] o_s_bresp, o_s_rresp, rs;
  logic [23:0] rl;
  int num_errors = 0, n_tests = 0, nwr = 0, nrc = 0, cyc = 0;

  wdrs_top dut (.i_clk_sys, .i_nrst, .i_stop_mode, .i_pin_reset, .i_wdt_refresh,
    .i_rc_tick, .i_port_pins, .o_wdt_reset, .o_stop_recover, .o_rc_run, .o_irq,
    .i_s_awaddr, .i_s_awvalid, .o_s_awready, .i_s_wdata, .i_s_wstrb, .i_s_wvalid,
    .o_s_wready, .o_s_bresp, .o_s_bvalid, .i_s_bready, .i_s_araddr, .i_s_arvalid,
    .o_s_arready, .o_s_rdata, .o_s_rresp, .o_s_rvalid, .i_s_rready);

  initial begin
    i_clk_sys = 0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_wdt_reset) nwr++;
    if (o_stop_recover) nrc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report;
    end
  end

  function automatic [31:0] st(input p, s, w, e, m);
    return {24'h00_0000, p, s, w, e, 3'h0, m};
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cyc_n(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  task rst;
    i_nrst <= 1'b0;
    cyc_n(8);
    i_nrst <= 1'b1;
    cyc_n(3);
  endtask
  task tick(input int n);
    repeat (n) begin
      i_rc_tick <= 1'b1;
      @(posedge i_clk_sys);
      i_rc_tick <= 1'b0;
      @(posedge i_clk_sys);
    end
  endtask
  task refresh;
    i_wdt_refresh <= 1'b1;
    @(posedge i_clk_sys);
    i_wdt_refresh <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  task pin_rst;
    i_pin_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_pin_reset <= 1'b0;
    @(posedge i_clk_sys);
  endtask
  // address and data offered together, each released once taken
  task wr(input [7:0] a, input [7:0] v);
    logic ka, kw, ta, tw;
    ka = 0;
    kw = 0;
    i_s_awaddr <= 32'(a);
    i_s_wdata <= 32'(v);
    i_s_awvalid <= 1'b1;
    i_s_wvalid <= 1'b1;
    while (!(ka && kw)) begin
      @(negedge i_clk_sys);
      ta = !ka && o_s_awready;
      tw = !kw && o_s_wready;
      @(posedge i_clk_sys);
      if (ta) i_s_awvalid <= 1'b0;
      if (tw) i_s_wvalid <= 1'b0;
      ka = ka | ta;
      kw = kw | tw;
    end
    do @(negedge i_clk_sys); while (!o_s_bvalid);
    rs = o_s_bresp;
    @(posedge i_clk_sys);
  endtask
  task rd(input [7:0] a);
    i_s_araddr <= 32'(a);
    i_s_arvalid <= 1'b1;
    do @(negedge i_clk_sys); while (!o_s_arready);
    @(posedge i_clk_sys);
    i_s_arvalid <= 1'b0;
    do @(negedge i_clk_sys); while (!o_s_rvalid);
    d = o_s_rdata;
    rs = o_s_rresp;
    @(posedge i_clk_sys);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    i_nrst = 0;
    i_stop_mode = 0;
    i_pin_reset = 0;
    i_wdt_refresh = 0;
    i_rc_tick = 0;
    i_port_pins = 0;
    i_s_awaddr = 0;
    i_s_wdata = 0;
    i_s_araddr = 0;
    i_s_wstrb = 4'hf;
    i_s_awvalid = 0;
    i_s_wvalid = 0;
    i_s_arvalid = 0;
    i_s_bready = 1;
    i_s_rready = 1;
    void'($urandom(32'h2f7e));
    rst;
    for (int i = 1; i < 4; i++) begin
      rd(8'(i * 4));
      chk(d, 32'h0000_00ff);
    end
    chk(32'(rs), 32'(`WDRS_RESP_OKAY));
    rd(8'h10);
    chk(32'(rs), 32'(`WDRS_RESP_SLVERR));
    wr(8'h10, 8'h00);
    chk(32'(rs), 32'(`WDRS_RESP_SLVERR));
    rl = 24'($urandom);
    wr(8'h04, rl[23:16]);
    chk(32'(rs), 32'(`WDRS_RESP_OKAY));
    wr(8'h08, rl[15:8]);
    wr(8'h0c, rl[7:0]);
    refresh;
    for (int i = 1; i < 4; i++) begin
      rd(8'(i * 4));
      chk(d, 32'(rl[24 - 8 * i +: 8]));
    end
    // small reload so the count runs out quickly
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h00);
    wr(8'h0c, 8'h02);
    refresh;
    tick(2);
    rd(8'h0c);
    chk(d, 32'h0);
    tick(1);
    cyc_n(2);
    chk(32'(nwr), 32'h1);
    rd(8'h00);
    chk(d, st(0, 0, 1, 0, 0));
    rd(8'h00);
    chk(d, 32'h0);
    chk(32'(o_irq), 32'h0);
    wr(8'h1c, 8'h01);
    cyc_n(2);
    chk(32'(o_irq), 32'h1);
    wr(8'h18, 8'h01);
    cyc_n(2);
    chk(32'(o_irq), 32'h0);
    i_stop_mode <= 1'b1;
    tick(3);
    cyc_n(2);
    chk(32'(nrc), 32'h1);
    chk(32'(nwr), 32'h1);
    rd(8'h00);
    chk(d, st(0, 1, 1, 0, 0));
    tick(3);
    pin_rst;
    en = 8'($urandom) & 8'h7e | 8'h01;
    wr(8'h14, en);
    rd(8'h14);
    chk(d, 32'(en));
    // a write with lane 0 off must leave the register alone
    i_s_wstrb <= 4'h0;
    wr(8'h14, ~en);
    i_s_wstrb <= 4'hf;
    rd(8'h14);
    chk(d, 32'(en));
    i_port_pins <= 8'h80;
    cyc_n(3);
    chk(32'(nrc), 32'h2);
    i_port_pins <= 8'h81;
    cyc_n(3);
    chk(32'(nrc), 32'h3);
    i_stop_mode <= 1'b0;
    rd(8'h00);
    chk(d, st(0, 1, 0, 0, 0));
    pin_rst;
    rd(8'h00);
    chk(d, st(0, 0, 0, 1, 0));
    wr(8'h00, 8'h01);
    i_stop_mode <= 1'b1;
    cyc_n(2);
    chk(32'(o_rc_run), 32'h0);
    tick(4);
    rd(8'h0c);
    chk(d, 32'h2);
    chk(32'(nrc), 32'h3);
    i_stop_mode <= 1'b0;
    cyc_n(2);
    rd(8'h00);
    chk(d, st(0, 0, 0, 0, 1));
    rst;
    rd(8'h00);
    chk(d, st(1, 0, 0, 0, 0));
    final_report;
  end
endmodule
